// ===== verilog/lcd_consts.svh
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH
// Register indices; byte address is four times the index.
`define LCD_IDX_MODE     16'hFFB0
`define LCD_IDX_STAT     16'hFFB1
`define LCD_IDX_CLK      16'hFFB2
`define LCD_IDX_BOOST    16'hFFB3
`define LCD_IDX_MEM_LO   16'hFA00
`define LCD_IDX_MEM_HI   16'hFA1B
`define LCD_SEGS         28
`define LCD_ADDR_W       18
`define LCD_RST_BYTE     8'h00
// Mode register bits.
`define LCD_MODE_DISP    7
`define LCD_MODE_BOOST   6
`define LCD_MODE_PINS    4
`define LCD_MODE_SLICE   0
// Clock register fields.
`define LCD_CLK_SRC_HI   3
`define LCD_CLK_SRC_LO   2
`define LCD_CLK_DIV_HI   1
`define LCD_CLK_DIV_LO   0
// Dividers: main clock by 32 << (code-1); scan clock 64 << code.
`define LCD_SRC_DIV_MIN  32
`define LCD_SCAN_DIV_MIN 64
`define LCD_RESP_OKAY    2'h0
`define LCD_RESP_SLVERR  2'h2
`endif

// ===== verilog/lcd_pkg.sv
package lcd_pkg;
    typedef enum logic [2:0] {
        LCD_RG_MODE, LCD_RG_STAT, LCD_RG_CLK, LCD_RG_BOOST, LCD_RG_MEM, LCD_RG_NONE
    } lcd_region_t;
    // Bias level of a pin: 0 ground, 1 one third, 2 two thirds, 3 full drive.
    typedef logic [1:0] lcd_level_t;
    typedef struct packed {
        logic       slice3;
        logic [1:0] src_sel;
        logic [1:0] scan_sel;
    } lcd_cfg_t;
endpackage : lcd_pkg

// ===== verilog/lcd_seg_driver.sv
// Functional notes
// - source select: sub clock or main/32,/64,/128.
// - scan clock is source divided 64..512.
// - frame is scan clock over slice count.
// - clock and boost registers reset zero.
// - boost bit picks reference level.
// - display memory is 28 consecutive bytes.
// - unused memory bytes are plain RAM.
// - memory upper nibble reads zero.
// - commons scan in turn per slice count.
// - fourth common left open in three-slice.
// - common slot n reads memory bit n.
// - bit one selects, zero deselects.
// - bit three unused in three-slice.
// - polarity alternates so no net DC.
// - full voltage only select on both.
// - each common slot lasts one scan clock.
// - slice bit: zero four, one three.
// - display off forces segment deselect.
// - pins off holds all pins ground, but the fourth common stays flagged open in three-slice.
//
// Register access over AXI4-Lite was decided locally.
`include "lcd_consts.svh"
`timescale 1ns/1ps
module lcd_seg_driver
    import lcd_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  clk_en,
    input  wire logic                  sub_osc_clock,
    input  wire logic [`LCD_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [`LCD_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output lcd_level_t [3:0]           common_level,
    output lcd_level_t [`LCD_SEGS-1:0] segment_level,
    output logic                       common_line_3_open,
    output logic                       booster_enable,
    output logic                       reference_sel
);
    function automatic lcd_region_t decode(input logic [`LCD_ADDR_W-1:0] a);
        logic [15:0] idx;
        idx = a[`LCD_ADDR_W-1:2];
        if (idx == `LCD_IDX_MODE) decode = LCD_RG_MODE;
        else if (idx == `LCD_IDX_STAT) decode = LCD_RG_STAT;
        else if (idx == `LCD_IDX_CLK) decode = LCD_RG_CLK;
        else if (idx == `LCD_IDX_BOOST) decode = LCD_RG_BOOST;
        else if (idx >= `LCD_IDX_MEM_LO && idx <= `LCD_IDX_MEM_HI) decode = LCD_RG_MEM;
        else decode = LCD_RG_NONE;
    endfunction : decode

    // 1/3 bias AC drive; polarity 1 mirrors every level.
    function automatic lcd_level_t bias(input logic sel, input logic pol, input logic com);
        lcd_level_t l;
        if (com) l = sel ? 2'h3 : 2'h1;
        else l = sel ? 2'h0 : 2'h2;
        bias = pol ? lcd_level_t'(2'h3 - l) : l;
    endfunction : bias

    logic [7:0] mode_q, mode_d, clk_q, clk_d, boost_q, boost_d;
    logic [3:0] mem_q [`LCD_SEGS];
    logic [3:0] mem_d [`LCD_SEGS];
    logic awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_go, rd_go;
    lcd_region_t wr_rg, rd_rg;
    logic [4:0] wr_ix, rd_ix;

    assign wr_go = awready_q && s_axi_awvalid && s_axi_wvalid;
    assign rd_go = arready_q && s_axi_arvalid;
    assign wr_rg = decode(s_axi_awaddr);
    assign rd_rg = decode(s_axi_araddr);
    assign wr_ix = s_axi_awaddr[6:2];
    assign rd_ix = s_axi_araddr[6:2];

    lcd_cfg_t act_q, act_d;
    logic [1:0] slot_q, slot_d;
    logic pol_q, pol_d;

    always_comb begin
        mode_d = mode_q;
        clk_d = clk_q;
        boost_d = boost_q;
        mem_d = mem_q;
        awready_d = 1'b0;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        arready_d = 1'b0;
        rvalid_d = rvalid_q && !s_axi_rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        // Address and data are taken together, so a lone one simply waits.
        if (!awready_q && !bvalid_q && s_axi_awvalid && s_axi_wvalid) begin
            awready_d = 1'b1;
        end
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d = (wr_rg == LCD_RG_NONE) ? `LCD_RESP_SLVERR : `LCD_RESP_OKAY;
            if (s_axi_wstrb[0]) begin
                case (wr_rg)
                    LCD_RG_MODE: mode_d = s_axi_wdata[7:0] & 8'hD1;
                    LCD_RG_CLK: clk_d = {4'h0, s_axi_wdata[3:0]};
                    LCD_RG_BOOST: boost_d = {7'h00, s_axi_wdata[0]};
                    LCD_RG_MEM: mem_d[wr_ix] = s_axi_wdata[3:0];
                    default: ;
                endcase
            end
        end
        if (!arready_q && !rvalid_q && s_axi_arvalid) begin
            arready_d = 1'b1;
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d = (rd_rg == LCD_RG_NONE) ? `LCD_RESP_SLVERR : `LCD_RESP_OKAY;
            case (rd_rg)
                LCD_RG_MODE: rdata_d = {24'h000000, mode_q};
                LCD_RG_STAT: rdata_d = {27'h0000000, act_q.slice3, pol_q, 1'b0, slot_q};
                LCD_RG_CLK: rdata_d = {24'h000000, clk_q};
                LCD_RG_BOOST: rdata_d = {24'h000000, boost_q};
                LCD_RG_MEM: rdata_d = {28'h0000000, mem_q[rd_ix]};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= `LCD_RST_BYTE;
            clk_q <= `LCD_RST_BYTE;
            boost_q <= `LCD_RST_BYTE;
            for (int i = 0; i < `LCD_SEGS; i++) mem_q[i] <= 4'h0;
            awready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h00000000;
        end else if (clk_en) begin
            mode_q <= mode_d;
            clk_q <= clk_d;
            boost_q <= boost_d;
            mem_q <= mem_d;
            awready_q <= awready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = awready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // The sub clock pin is sampled; a new level counts once stages two and three agree.
    logic sub_s1_q, sub_s2_q, sub_s3_q, sub_lvl_q, sub_lvl_d, sub_rise;
    logic [6:0] pre_q, pre_d;
    logic [8:0] div_q, div_d;
    logic src_tick, scan_tick, frame_end, pins_on;
    logic [6:0] src_mask;
    logic [8:0] scan_top;
    lcd_level_t [3:0] com_q, com_d;
    lcd_level_t [`LCD_SEGS-1:0] seg_q, seg_d;
    logic open_q, open_d;

    assign sub_rise = (sub_s2_q == sub_s3_q) && sub_s3_q && !sub_lvl_q;
    assign pins_on = mode_q[`LCD_MODE_PINS];
    assign src_mask = 7'(`LCD_SRC_DIV_MIN * (1 << act_q.src_sel) / 2 - 1);
    assign src_tick = (act_q.src_sel == 2'h0) ? sub_rise : ((pre_q & src_mask) == src_mask);
    assign scan_top = 9'(`LCD_SCAN_DIV_MIN * (1 << act_q.scan_sel) - 1);
    assign scan_tick = src_tick && (div_q == scan_top);
    assign frame_end = scan_tick && (slot_q == (act_q.slice3 ? 2'h2 : 2'h3));

    always_comb begin
        sub_lvl_d = (sub_s2_q == sub_s3_q) ? sub_s3_q : sub_lvl_q;
        pre_d = 7'(pre_q + 7'h01);
        div_d = src_tick ? ((div_q == scan_top) ? 9'h000 : 9'(div_q + 9'h001)) : div_q;
        slot_d = slot_q;
        pol_d = pol_q;
        act_d = act_q;
        if (!pins_on || frame_end) begin
            // Settings are picked up only at a frame end or while the pins are off, so a scan never mixes modes.
            slot_d = 2'h0;
            act_d = '{slice3: mode_q[`LCD_MODE_SLICE],
                      src_sel: clk_q[`LCD_CLK_SRC_HI:`LCD_CLK_SRC_LO],
                      scan_sel: clk_q[`LCD_CLK_DIV_HI:`LCD_CLK_DIV_LO]};
            pol_d = pins_on ? !pol_q : 1'b0;
            if (!pins_on) div_d = 9'h000;
        end else if (scan_tick) begin
            slot_d = 2'(slot_q + 2'h1);
        end
        for (int i = 0; i < 4; i++) begin
            com_d[i] = bias(slot_q == 2'(i), pol_q, 1'b1);
        end
        if (act_q.slice3) com_d[3] = 2'h0;
        for (int j = 0; j < `LCD_SEGS; j++) begin
            // Slot 3 never occurs with three slices, so bit 3 stays free.
            seg_d[j] = bias(mode_q[`LCD_MODE_DISP] && mem_q[j][slot_q], pol_q, 1'b0);
        end
        open_d = act_q.slice3;
        if (!pins_on) begin
            com_d = '0;
            seg_d = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
            sub_lvl_q <= 1'b0;
            pre_q <= 7'h00;
            div_q <= 9'h000;
            slot_q <= 2'h0;
            pol_q <= 1'b0;
            act_q <= '0;
            com_q <= '0;
            seg_q <= '0;
            open_q <= 1'b0;
        end else if (clk_en) begin
            sub_s1_q <= sub_osc_clock;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
            sub_lvl_q <= sub_lvl_d;
            pre_q <= pre_d;
            div_q <= div_d;
            slot_q <= slot_d;
            pol_q <= pol_d;
            act_q <= act_d;
            com_q <= com_d;
            seg_q <= seg_d;
            open_q <= open_d;
        end
    end

    assign common_level = com_q;
    assign segment_level = seg_q;
    assign common_line_3_open = open_q;
    assign booster_enable = mode_q[`LCD_MODE_BOOST];
    assign reference_sel = boost_q[0];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_clk;
        clk_en && wr_go && wr_rg == LCD_RG_CLK && s_axi_wstrb[0];
    endsequence
    sequence s_pins_off;
        clk_en && !pins_on;
    endsequence

    property p_clk_write;
        s_wr_clk |=> clk_q == {4'h0, $past(s_axi_wdata[3:0])};
    endproperty
    a_clk_write: assert property (p_clk_write) else $error("clock reg not written");
    property p_boost_write;
        clk_en && wr_go && wr_rg == LCD_RG_BOOST && s_axi_wstrb[0]
            |=> reference_sel == $past(s_axi_wdata[0]) && boost_q[7:1] == 7'h00;
    endproperty
    a_boost_write: assert property (p_boost_write) else $error("boost bit wrong");
    property p_mem_upper;
        clk_en && rd_go && rd_rg == LCD_RG_MEM |=> s_axi_rdata[31:4] == 28'h0000000;
    endproperty
    a_mem_upper: assert property (p_mem_upper) else $error("memory upper bits set");
    property p_pins_ground;
        s_pins_off |=> common_level == '0 && segment_level == '0;
    endproperty
    a_pins_ground: assert property (p_pins_ground) else $error("pins not grounded");
    property p_frame_wrap;
        clk_en && pins_on && frame_end |=> slot_q == 2'h0 && pol_q != $past(pol_q);
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");
    property p_common_line_3_open;
        clk_en && pins_on && act_q.slice3 |=> common_level[3] == 2'h0;
    endproperty
    a_common_line_3_open: assert property (p_common_line_3_open) else $error("fourth common driven");
    property p_disp_off;
        clk_en && pins_on && !mode_q[`LCD_MODE_DISP]
            |=> segment_level[0] == 2'h1 || segment_level[0] == 2'h2;
    endproperty
    a_disp_off: assert property (p_disp_off) else $error("segment not deselected");
    property p_slot_hold;
        clk_en && pins_on && !scan_tick |=> slot_q == $past(slot_q);
    endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("slot moved early");
    property p_src_gap;
        clk_en && act_q.src_sel == 2'h1 && src_tick
            |=> (!src_tick || act_q.src_sel != 2'h1) [*8];
    endproperty
    a_src_gap: assert property (p_src_gap) else $error("source tick too soon");
endmodule : lcd_seg_driver

// ===== verif/lcd_panel_model.sv
`timescale 1ns/1ps
`include "lcd_consts.svh"
// Passive glass. Each polarity of full drive is remembered separately, so a
// pixel that is lit in only one polarity shows up as a DC fault.
module lcd_panel_model
    import lcd_pkg::*;
(
    input  wire logic                       aclk,
    input  wire logic                       clear,
    input  wire lcd_level_t [3:0]           common_level,
    input  wire lcd_level_t [`LCD_SEGS-1:0] segment_level,
    output logic [3:0][`LCD_SEGS-1:0]       lit_pos,
    output logic [3:0][`LCD_SEGS-1:0]       lit_neg
);
    always @(posedge aclk) begin
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < `LCD_SEGS; s++) begin
                if (clear) begin
                    lit_pos[c][s] <= 1'h0;
                    lit_neg[c][s] <= 1'h0;
                end else begin
                    if (common_level[c] == 2'h3 && segment_level[s] == 2'h0) begin
                        lit_pos[c][s] <= 1'h1;
                    end
                    if (common_level[c] == 2'h0 && segment_level[s] == 2'h3) begin
                        lit_neg[c][s] <= 1'h1;
                    end
                end
            end
        end
    end
endmodule : lcd_panel_model

// ===== verif/lcd_seg_driver_test.sv
`timescale 1ns/1ps
`include "lcd_consts.svh"
module lcd_seg_driver_test
    import lcd_pkg::*;
;
    localparam logic [1:0] ok_r = `LCD_RESP_OKAY;
    localparam logic [1:0] err_r = `LCD_RESP_SLVERR;
    // Sub clock period is 8 aclk cycles, so a sub-clock slot is 8 times its divider.
    localparam logic [7:0] cfg [6] = '{8'h00, 8'h05, 8'h08, 8'h03, 8'h0C, 8'h02};
    localparam int         slot [6] = '{512, 4096, 4096, 4096, 8192, 2048};
    logic                  aclk = 1'h0;
    logic                  aresetn = 1'h0;
    logic                  sub_clk = 1'h0;
    logic                  awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic                  clear = 1'h0;
    logic                  ce = 1'h1;
    lcd_level_t [3:0]      held;
    logic [17:0]           awa = 18'h0, ara = 18'h0;
    logic [31:0]           wd = 32'h0;
    logic                  awr, wrdy, bv, arr, rv, open3, boost, ref_sel;
    logic [1:0]            br, rr;
    logic [31:0]           rdat;
    lcd_level_t [3:0]      com;
    lcd_level_t [27:0]     seg;
    logic [3:0][27:0]      lit_pos, lit_neg;
    logic [3:0]            pat [28];
    int                    mismatches = 0, compares = 0;

    always #2.5 aclk = ~aclk;
    always #20 sub_clk = ~sub_clk;

    lcd_seg_driver dut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(ce), .sub_osc_clock(sub_clk),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .common_level(com), .segment_level(seg),
        .common_line_3_open(open3), .booster_enable(boost), .reference_sel(ref_sel)
    );
    lcd_panel_model panel (
        .aclk(aclk), .clear(clear), .common_level(com), .segment_level(seg),
        .lit_pos(lit_pos), .lit_neg(lit_neg)
    );

    task automatic test_done;
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic fail;
        mismatches++;
        test_done();
    endtask : fail

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic await(ref logic f);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (f !== 1'h1 && n < 99);
        if (n >= 99) fail();
    endtask : await

    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        awa <= {idx, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        await(awr);
        awv <= 1'h0;
        wv <= 1'h0;
        await(bv);
        bry <= 1'h0;
        chk("bresp", 32'(er), 32'(br));
    endtask : wr

    task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        ara <= {idx, 2'h0};
        arv <= 1'h1;
        rry <= 1'h1;
        await(arr);
        arv <= 1'h0;
        await(rv);
        rry <= 1'h0;
        chk("rdata", e, rdat);
        chk("rresp", 32'(er), 32'(rr));
    endtask : rd

    function automatic logic sel(input lcd_level_t v);
        return v === 2'h0 || v === 2'h3;
    endfunction : sel

    task automatic wait_com(input int c, input logic s, output int n);
        n = 0;
        while (sel(com[c]) != s && n < 70000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 70000) fail();
    endtask : wait_com

    // The first slot may start short after enabling; the third is always a whole one.
    task automatic slot_len(input int e);
        int n;
        wait_com(0, 1'h0, n);
        wait_com(2, 1'h1, n);
        wait_com(3, 1'h1, n);
        chk("slot_cycles", 32'(e), 32'(n));
    endtask : slot_len

    // The lead-in must outlast one frame when a new setting waits for a boundary.
    task automatic run(input int pre);
        repeat (pre) @(posedge aclk);
        clear <= 1'h1;
        @(posedge aclk);
        clear <= 1'h0;
        repeat (6144) @(posedge aclk);
    endtask : run

    task automatic pix(input logic three, input logic off);
        logic [27:0] e;
        for (int c = 0; c < (three ? 3 : 4); c++) begin
            for (int s = 0; s < 28; s++) e[s] = pat[s][c] & ~off;
            chk("lit_pos", 32'(e), 32'(lit_pos[c]));
            chk("lit_neg", 32'(e), 32'(lit_neg[c]));
        end
    endtask : pix

    initial begin
        for (int s = 0; s < 28; s++) pat[s] = 4'(s) ^ 4'h6;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`LCD_IDX_CLK, 32'h0, ok_r);
        rd(`LCD_IDX_BOOST, 32'h0, ok_r);
        rd(`LCD_IDX_MEM_HI, 32'h0, ok_r);
        chk("ref_sel", 32'h0, 32'(ref_sel));
        for (int s = 0; s < 28; s++) begin
            wr(`LCD_IDX_MEM_LO + 16'(s), {4'hF, pat[s]}, ok_r);
            rd(`LCD_IDX_MEM_LO + 16'(s), 32'(pat[s]), ok_r);
        end
        wr(16'hFA1C, 8'h01, err_r);
        rd(16'hFA1C, 32'h0, err_r);
        for (int i = 0; i < 6; i++) begin
            wr(`LCD_IDX_MODE, 8'h00, ok_r);
            wr(`LCD_IDX_CLK, cfg[i], ok_r);
            rd(`LCD_IDX_CLK, 32'(cfg[i]), ok_r);
            wr(`LCD_IDX_MODE, 8'h50, ok_r);
            slot_len(slot[i]);
        end
        wr(`LCD_IDX_MODE, 8'h00, ok_r);
        wr(`LCD_IDX_CLK, 8'h00, ok_r);
        wr(`LCD_IDX_BOOST, 8'h01, ok_r);
        rd(`LCD_IDX_BOOST, 32'h1, ok_r);
        chk("ref_sel", 32'h1, 32'(ref_sel));
        wr(`LCD_IDX_MODE, 8'h40, ok_r);
        chk("booster", 32'h1, 32'(boost));
        wr(`LCD_IDX_MODE, 8'h50, ok_r);
        wr(`LCD_IDX_MODE, 8'hD0, ok_r);
        run(2048);
        pix(1'h0, 1'h0);
        // Three slices on the fastest sub-clock scan rate is forbidden, so slow it first.
        wr(`LCD_IDX_MODE, 8'h00, ok_r);
        wr(`LCD_IDX_CLK, 8'h01, ok_r);
        wr(`LCD_IDX_MODE, 8'h40, ok_r);
        wr(`LCD_IDX_MODE, 8'h50, ok_r);
        wr(`LCD_IDX_MODE, 8'hD0, ok_r);
        wr(`LCD_IDX_MODE, 8'hD1, ok_r);
        rd(`LCD_IDX_MODE, 32'hD1, ok_r);
        run(4096);
        chk("common_line_3_open", 32'h1, 32'(open3));
        pix(1'h1, 1'h0);
        wr(`LCD_IDX_MODE, 8'h51, ok_r);
        run(2048);
        pix(1'h1, 1'h1);
        ce <= 1'h0;
        @(posedge aclk);
        held = com;
        repeat (1100) @(posedge aclk);
        chk("frozen_com", 32'(held), 32'(com));
        ce <= 1'h1;
        wr(`LCD_IDX_MODE, 8'h41, ok_r);
        repeat (4) @(posedge aclk);
        chk("com_level", 32'h0, 32'(com));
        chk("seg_any", 32'h0, 32'(|seg));
        rd(`LCD_IDX_STAT, 32'h10, ok_r);
        test_done();
    end
endmodule : lcd_seg_driver_test
